// ### dsb_burst_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Load low, read-not-write low latches write address; data beats follow next cycle.
// - Load low, read-not-write high latches read address; beats leave on the next two clock cycles.
// - After reset the port is deselected with data outputs floating.
// - Each access moves two words at address plus zero then plus one.
// - Write data taken on both input clock phases; read data on output phases.
// - In 18-bit width select 0 gates bits 8:0, select 1 gates 17:9.
// - In 8-bit width nibble select 0 gates bits 3:0, select 1 gates 7:4.
// - All selects high during a beat writes nothing for that beat.
// - In 9-bit width one byte select gates bits 8:0 each beat.
// - In 36-bit width four selects gate the four nine-bit bytes.
// - Writes are posted in registers and committed later, never clashing with reads.
module dsb_burst_port
	import dsb_pkg::*;
#(
	parameter int DATA_W = dsb_pkg::ORG_X18_W,
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic single_clock_strap,
	input wire logic load_strobe_n,
	input wire logic read_not_write,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [((DATA_W == dsb_pkg::ORG_X8_W) ? 2 : (DATA_W+8)/9)-1:0] write_select_n,
	input wire logic beat_phase,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_data_oe,
	output logic single_clock_mode,
	output logic write_ready
);
	import dsb_pkg::*;
	localparam int SEL_W = (DATA_W == ORG_X8_W) ? 2 : (DATA_W + 8) / 9;
	localparam int LANE_W = (DATA_W == ORG_X8_W) ? NIBBLE_W : BYTE_W;
	localparam int DEPTH = 2 ** (ADDR_W + 1);
	localparam int WENT_W = ADDR_W + 1 + DATA_W + SEL_W;

	logic rst_s1_q, rst_n_q;
	logic strap_cap_q, strap_cap_d, strap_done_q;
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic wr_pend_q, wr_pend_d;
	logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic wr_beat_q, wr_beat_d;
	dsb_rd_e rd_state_q, rd_state_d;
	logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
	logic [DATA_W-1:0] rd_data_d;
	logic rd_oe_d;
	logic [DATA_W-1:0] lane_mask;
	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [WENT_W-1:0] f_in_data, f_out_data;
	logic [ADDR_W:0] c_addr;
	logic [DATA_W-1:0] c_data;
	logic [SEL_W-1:0] c_sel_n;
	logic start_wr, start_rd, reading;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Strap captured once after reset release
	always_comb begin
		strap_cap_d = strap_done_q ? strap_cap_q : single_clock_strap;
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			strap_cap_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else begin
			strap_cap_q <= strap_cap_d;
			strap_done_q <= 1'b1;
		end
	end
	assign single_clock_mode = strap_cap_q;

	// Command decode on the load edge
	assign start_wr = !load_strobe_n && !read_not_write && !beat_phase;
	assign start_rd = !load_strobe_n && read_not_write && !beat_phase;
	assign reading = (rd_state_q != DSB_RD_IDLE);

	// Write beat capture: first beat on rise, second on complementary rise
	always_comb begin
		wr_pend_d = wr_pend_q;
		wr_addr_d = wr_addr_q;
		wr_beat_d = wr_beat_q;
		f_in_valid = 1'b0;
		f_in_data = '0;
		if (wr_pend_q) begin
			f_in_valid = 1'b1;
			f_in_data = {wr_addr_q, wr_beat_q, wr_data, write_select_n};
			if (f_in_ready) begin
				wr_beat_d = !wr_beat_q;
				if (wr_beat_q == BURST_OFS_SECOND) begin
					wr_pend_d = 1'b0;
				end
			end
		end
		if (start_wr && !(wr_pend_q && wr_beat_q == BURST_OFS_FIRST)) begin
			wr_pend_d = 1'b1;
			wr_addr_d = addr;
			wr_beat_d = BURST_OFS_FIRST;
		end
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			wr_beat_q <= 1'b0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			wr_beat_q <= wr_beat_d;
		end
	end
	assign write_ready = f_in_ready;

	// Posted write buffer between capture and array
	dsb_fifo #(
		.WIDTH(WENT_W),
		.DEPTH(WFIFO_DEPTH)
	) u_wfifo (
		.clk(clk),
		.rst_n(rst_n_q),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// Commit only when no read beat uses the array
	assign f_out_ready = !reading;
	assign {c_addr, c_data, c_sel_n} = f_out_data;

	// Per-lane write masks
	genvar g;
	generate
		for (g = 0; g < SEL_W; g++) begin : g_lane
			localparam int LO = g * LANE_W;
			localparam int HI = ((g + 1) * LANE_W > DATA_W) ? DATA_W - 1 : (g + 1) * LANE_W - 1;
			assign lane_mask[HI:LO] = {(HI - LO + 1){!c_sel_n[g]}};
		end
	endgenerate

	// Array update; unselected lanes keep their contents
	always_ff @(posedge clk) begin
		if (f_out_valid && f_out_ready) begin
			mem_q[c_addr] <= (mem_q[c_addr] & ~lane_mask) | (c_data & lane_mask);
		end
	end

	// Read sequencer
	always_comb begin
		rd_state_d = rd_state_q;
		rd_addr_d = rd_addr_q;
		rd_data_d = rd_data;
		rd_oe_d = rd_data_oe;
		case (rd_state_q)
			DSB_RD_IDLE: begin
				if (start_rd) begin
					rd_state_d = DSB_RD_BEAT0;
					rd_addr_d = addr;
				end else if (!load_strobe_n || !beat_phase) begin
					rd_oe_d = 1'b0;
				end
			end
			DSB_RD_BEAT0: begin
				rd_data_d = mem_q[{rd_addr_q, BURST_OFS_FIRST}];
				rd_oe_d = 1'b1;
				rd_state_d = DSB_RD_BEAT1;
			end
			DSB_RD_BEAT1: begin
				rd_data_d = mem_q[{rd_addr_q, BURST_OFS_SECOND}];
				rd_oe_d = 1'b1;
				rd_state_d = DSB_RD_IDLE;
				if (start_rd) begin
					rd_state_d = DSB_RD_BEAT0;
					rd_addr_d = addr;
				end
			end
			default: rd_state_d = DSB_RD_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_state_q <= DSB_RD_IDLE;
			rd_addr_q <= '0;
			rd_data <= '0;
			rd_data_oe <= 1'b0;
		end else begin
			rd_state_q <= rd_state_d;
			rd_addr_q <= rd_addr_d;
			rd_data <= rd_data_d;
			rd_data_oe <= rd_oe_d;
		end
	end

	// Checks
	a_read_first_beat: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rd_state_q == DSB_RD_IDLE && start_rd) |=> ##1 rd_data_oe)
		else $error("read beat not driven");
	a_read_two_beats: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rd_state_q == DSB_RD_BEAT0) |=> (rd_state_q == DSB_RD_BEAT1) ##1 rd_data_oe)
		else $error("second beat missing");
	a_commit_no_clash: assert property (@(posedge clk) disable iff (!rst_n_q)
		reading |-> !(f_out_valid && f_out_ready))
		else $error("commit during read");
	a_write_beats_pair: assert property (@(posedge clk) disable iff (!rst_n_q)
		($rose(wr_pend_q) && f_in_ready) |=> (wr_beat_q == BURST_OFS_SECOND))
		else $error("write beat order wrong");
	a_reset_float: assert property (@(posedge clk)
		!rst_n_q |-> !rd_data_oe)
		else $error("output driven in reset");
	a_strap_fixed: assert property (@(posedge clk) disable iff (!rst_n_q)
		$past(strap_done_q) |-> $stable(strap_cap_q))
		else $error("strap changed");
	a_lane_mask_none: assert property (@(posedge clk) disable iff (!rst_n_q)
		(&c_sel_n) |-> (lane_mask == '0))
		else $error("mask with no select");
	a_nop_float: assert property (@(posedge clk) disable iff (!rst_n_q)
		(rd_state_q == DSB_RD_IDLE && load_strobe_n && !beat_phase) |=> !rd_data_oe)
		else $error("nop left outputs driven");
endmodule

// ### dsb_ctl_model.sv
`timescale 1ns/1ps
module dsb_ctl_model (
	input wire logic clk,
	output logic strap,
	output logic load_strobe_n,
	output logic rnw,
	output logic [7:0] addr,
	output logic [17:0] wd,
	output logic [1:0] sel_n,
	output logic ph
);
	// Idle bus, strap held high from power-on
	initial begin
		strap = 1'b1;
		load_strobe_n = 1'b1;
		rnw = 1'b0;
		addr = 8'h00;
		wd = 18'h00000;
		sel_n = 2'h3;
		ph = 1'b0;
	end
	// Beat phase alternates every cycle
	always @(posedge clk) ph <= #1 ~ph;
	// Return just after the edge before a load-phase edge
	task automatic align();
		do @(posedge clk); while (ph !== 1'b1);
		#1;
	endtask
	// Write load, then two beats with their own selects
	task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
		align();
		load_strobe_n = 1'b0;
		rnw = 1'b0;
		addr = a;
		@(posedge clk);
		#1 load_strobe_n = 1'b1;
		addr = ~a;
		wd = d0;
		sel_n = s0;
		@(posedge clk);
		#1 wd = d1;
		sel_n = s1;
		@(posedge clk);
		#1 wd = ~d1;
		sel_n = ~s1;
	endtask
	// Read load; address scrambled once taken
	task automatic rd(input logic [7:0] a);
		align();
		load_strobe_n = 1'b0;
		rnw = 1'b1;
		addr = a;
		@(posedge clk);
		#1 load_strobe_n = 1'b1;
		rnw = 1'b0;
		addr = ~a;
	endtask
endmodule

// ### dsb_fifo.sv
`timescale 1ns/1ps
module dsb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Handshakes and pointer advance
	always_comb begin
		in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ;
		out_valid = (cnt_q != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_d = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
		rp_d = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		out_data = mem_q[rp_q];
	end

	// Pointer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule

// ### dsb_pkg.sv
package dsb_pkg;
	// Organisation widths
	localparam int ORG_X8_W = 8;
	localparam int ORG_X9_W = 9;
	localparam int ORG_X18_W = 18;
	localparam int ORG_X36_W = 36;
	// Lane widths
	localparam int NIBBLE_W = 4;
	localparam int BYTE_W = 9;
	// Burst offsets
	localparam logic BURST_OFS_FIRST = 1'b0;
	localparam logic BURST_OFS_SECOND = 1'b1;
	// Posted write FIFO depth
	localparam int WFIFO_DEPTH = 8;
	// Latency from load edge to first data beat, in cycles
	localparam int LAT_BEAT = 1;
	// Read pipeline phase
	typedef enum logic [1:0] {
		DSB_RD_IDLE,
		DSB_RD_BEAT0,
		DSB_RD_BEAT1
	} dsb_rd_e;
endpackage

// ### test_ddr_sio_sram_burst_port.sv
`timescale 1ns/1ps
module test_ddr_sio_sram_burst_port;
	import dsb_pkg::*;
	logic clk, rstn, strap, load_strobe_n, rnw, ph, oe, mode, wrdy;
	logic [7:0] addr;
	logic [17:0] wd, rdd;
	logic [1:0] sel_n;
	logic [17:0] mem [0:511];
	logic [17:0] exp_q [$];
	logic [4:0] hist = 5'h00;
	int errors = 0;
	int num_checks = 0;
	dsb_burst_port #(.DATA_W(ORG_X18_W), .ADDR_W(8)) DUT (.clk(clk), .rstn(rstn),
		.single_clock_strap(strap), .load_strobe_n(load_strobe_n), .read_not_write(rnw),
		.addr(addr), .wr_data(wd), .write_select_n(sel_n), .beat_phase(ph), .rd_data(rdd),
		.rd_data_oe(oe), .single_clock_mode(mode), .write_ready(wrdy));
	dsb_ctl_model ctl (.clk(clk), .strap(strap), .load_strobe_n(load_strobe_n), .rnw(rnw),
		.addr(addr), .wd(wd), .sel_n(sel_n), .ph(ph));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk_w(input string nm, input logic [17:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Lane merge of one beat into the reference word
	function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] s);
		mrg = o;
		if (!s[0]) mrg[8:0] = n[8:0];
		if (!s[1]) mrg[17:9] = n[17:9];
	endfunction
	// Bounded wait for room, then a write with reference update
	task automatic wr_ref(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
		int n;
		n = 0;
		while (wrdy !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 200) begin
				errors++;
				close_out();
			end
		end
		ctl.wr(a, d0, d1, s0, s1);
		mem[{a, 1'b0}] = mrg(mem[{a, 1'b0}], d0, s0);
		mem[{a, 1'b1}] = mrg(mem[{a, 1'b1}], d1, s1);
	endtask
	// Let posted writes settle, then read all eight bursts, one read load every two cycles
	task automatic rd_all(input string nm);
		repeat (30) @(posedge clk);
		for (int a = 0; a < 8; a++) begin
			exp_q.push_back(mem[{a[7:0], 1'b0}]);
			exp_q.push_back(mem[{a[7:0], 1'b1}]);
			ctl.rd(a[7:0]);
		end
		repeat (6) @(posedge clk);
		$display("test %s done", nm);
	endtask
	// Remember taken read loads
	always @(posedge clk) hist <= {hist[3:0], rstn & ~load_strobe_n & rnw & ~ph};
	// Beats one and two edges after a read load, floating once no read load is in the last five edges
	always @(negedge clk) begin
		if (hist[1] | hist[2]) begin
			chk_b("oe", 1'b1, oe);
			chk_w("beat", exp_q.pop_front(), rdd);
		end else if (hist == 5'h00) begin
			chk_b("float", 1'b0, oe);
		end
	end
	initial begin
		rstn = 1'b0;
		void'($urandom(32'h628A));
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_b("mode", 1'b1, mode);
		$display("test reset done");
		for (int i = 0; i < 8; i++) wr_ref(i[7:0], 18'($urandom), 18'($urandom), 2'h0, 2'h0);
		rd_all("full");
		for (int i = 0; i < 16; i++) wr_ref(8'(i % 8), 18'($urandom), 18'($urandom), i[1:0], i[3:2]);
		rd_all("selects");
		for (int i = 0; i < 40; i++) begin
			wr_ref(8'($urandom % 8), 18'($urandom), 18'($urandom), 2'($urandom), 2'($urandom));
		end
		rd_all("random");
		close_out();
	end
endmodule
